// [rsl_pin_sync.sv]
module rsl_pin_sync (
  input wire logic i_clk,
  input wire logic i_rst_n,
  rsl_sync_if.sync sif
);

  // ----------------------------------------------------------------
  // three stage synchroniser per pin
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < rsl_pkg::RSL_NUM_PINS; g++) begin : g_pin
      logic s1_r;
      logic s2_r;
      logic s3_r;
      logic lvl_r;

      // s1 only feeds s2, never any logic
      always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
          s1_r <= 1'b0;
          s2_r <= 1'b0;
          s3_r <= 1'b0;
        end else begin
          s1_r <= sif.raw[g];
          s2_r <= s1_r;
          s3_r <= s2_r;
        end
      end

      // a change counts only once stages two and three agree
      always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
          lvl_r <= 1'b0;
        end else if (s2_r == s3_r) begin
          lvl_r <= s3_r;
        end
      end

      assign sif.level[g] = lvl_r;
    end
  endgenerate

endmodule

// [rsl_pkg.sv]
package rsl_pkg;

  // ----------------------------------------------------------------
  // register map, word aligned byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] RSL_ADR_CAUSE   = 8'h00;  // reset_cause_status
  localparam logic [7:0] RSL_ADR_EVSTAT  = 8'h04;  // sticky event status, clear on read
  localparam logic [7:0] RSL_ADR_EVMASK  = 8'h08;  // event mask, same layout

  // ----------------------------------------------------------------
  // reset_cause_status field positions
  // ----------------------------------------------------------------
  localparam int RSL_BIT_TRAP  = 15;  // trap_conflict_flag
  localparam int RSL_BIT_ILLOP = 14;  // illegal_op_flag
  localparam int RSL_BIT_EXTERNAL_PIN_RESET_FLAG  = 7;   // external_pin_reset_flag
  localparam int RSL_BIT_SWRST = 6;   // software_reset_flag
  localparam int RSL_BIT_WDSEN = 5;   // watchdog_soft_enable
  localparam int RSL_BIT_WATCHDOG_TIMEOUT_FLAG  = 4;   // watchdog_timeout_flag
  localparam int RSL_BIT_BOR   = 1;   // brownout_flag
  localparam int RSL_BIT_POR   = 0;   // power-on flag

  // implemented bits; 13..8 and 3..2 read as zero here
  localparam logic [15:0] RSL_CAUSE_IMPL  = 16'hC0F3;
  localparam logic [15:0] RSL_CAUSE_RST   = 16'h0001;
  localparam logic [15:0] RSL_EVSTAT_RST  = 16'h0000;
  localparam logic [15:0] RSL_EVMASK_RST  = 16'h0000;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int RSL_CLK_PERIOD_NS = 20;
  localparam int RSL_MRST_HOLD_NS  = 100;  // least master reset width
  localparam int RSL_MRST_HOLD_CYC =
    (RSL_MRST_HOLD_NS + RSL_CLK_PERIOD_NS - 1) / RSL_CLK_PERIOD_NS;
  localparam logic [3:0] RSL_MRST_HOLD_CNT = 4'(RSL_MRST_HOLD_CYC);

  // number of pin sources passed through the synchroniser
  localparam int RSL_NUM_PINS = 2;
  localparam int RSL_PIN_MASTER_CLEAR_PIN = 0;
  localparam int RSL_PIN_BOR  = 1;

endpackage

// [rsl_reset_source_status.sv]
// Overview of operation
// - any active reset source asserts master reset
// - each reset sets its matching cause flag
// - power-on clears all flags, sets bit zero
// - software may set/clear flags, no reset
// - undefined registers survive non-power-on resets
// - trap conflict reset sets bit 15
// - illegal opcode/address/uninit pointer sets bit 14
// - master clear pin reset sets bit 7
// - watchdog timeout reset sets bit 4
// - brown-out reset sets bit 1
// - fuse bit one forces watchdog enabled
//
// The implementer's own choices: register access over Wishbone and the register offsets.
module rsl_reset_source_status (
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_master_clear_pin_n,
  input  wire logic        i_brownout,
  input  wire logic        i_watchdog_timeout,
  input  wire logic        i_trap_conflict,
  input  wire logic        i_illegal_opcode,
  input  wire logic        i_illegal_addr_mode,
  input  wire logic        i_uninit_wreg_ptr,
  input  wire logic        i_software_reset,
  input  wire logic        i_watchdog_fuse_enable,
  input  wire logic        i_wb_cyc,
  input  wire logic        i_wb_stb,
  input  wire logic        i_wb_we,
  input  wire logic [7:0]  i_wb_adr,
  input  wire logic [31:0] i_wb_dat,
  input  wire logic [3:0]  i_wb_sel,
  output logic      [31:0] o_wb_dat,
  output logic             o_wb_ack,
  output logic             o_master_reset_signal,
  output logic             o_watchdog_enable,
  output logic             o_irq
);

  // ----------------------------------------------------------------
  // pin synchronisation
  // ----------------------------------------------------------------
  rsl_sync_if sif ();

  // master clear pin is active low; present both pins active high
  assign sif.raw[rsl_pkg::RSL_PIN_MASTER_CLEAR_PIN] = ~i_master_clear_pin_n;
  assign sif.raw[rsl_pkg::RSL_PIN_BOR]  = i_brownout;

  rsl_pin_sync u_pin_sync (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .sif     (sif)
  );

  logic master_clear_pin_lvl;
  logic bor_lvl;
  logic illegal_any;

  assign master_clear_pin_lvl    = sif.level[rsl_pkg::RSL_PIN_MASTER_CLEAR_PIN];
  assign bor_lvl     = sif.level[rsl_pkg::RSL_PIN_BOR];
  // three distinct faults share one flag
  assign illegal_any = i_illegal_opcode | i_illegal_addr_mode | i_uninit_wreg_ptr;

  // ----------------------------------------------------------------
  // source edges for the event status
  // ----------------------------------------------------------------
  logic master_clear_pin_prev_r;
  logic bor_prev_r;

  // previous filtered pin levels, for rising edge detection
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      master_clear_pin_prev_r <= 1'b0;
      bor_prev_r  <= 1'b0;
    end else begin
      master_clear_pin_prev_r <= master_clear_pin_lvl;
      bor_prev_r  <= bor_lvl;
    end
  end

  // flag set terms: level while the source is active
  logic [15:0] cause_set;
  // interrupt event terms: one pulse per reset occurrence
  logic [15:0] ev_set;

  always_comb begin
    cause_set                           = 16'h0000;
    cause_set[rsl_pkg::RSL_BIT_TRAP]    = i_trap_conflict;
    cause_set[rsl_pkg::RSL_BIT_ILLOP]   = illegal_any;
    cause_set[rsl_pkg::RSL_BIT_EXTERNAL_PIN_RESET_FLAG]    = master_clear_pin_lvl;
    cause_set[rsl_pkg::RSL_BIT_SWRST]   = i_software_reset;
    cause_set[rsl_pkg::RSL_BIT_WATCHDOG_TIMEOUT_FLAG]    = i_watchdog_timeout;
    cause_set[rsl_pkg::RSL_BIT_BOR]     = bor_lvl;
  end

  // pins give edges; core sources are already one-cycle pulses
  always_comb begin
    ev_set                         = cause_set;
    ev_set[rsl_pkg::RSL_BIT_EXTERNAL_PIN_RESET_FLAG]  = master_clear_pin_lvl & ~master_clear_pin_prev_r;
    ev_set[rsl_pkg::RSL_BIT_BOR]   = bor_lvl & ~bor_prev_r;
  end

  // ----------------------------------------------------------------
  // master reset generation
  // ----------------------------------------------------------------
  logic       src_active;
  logic [3:0] hold_cnt_r;

  // any source active; the set is everything except the power-on flag
  assign src_active = |cause_set;

  // stretch so even a one-cycle source gives a full-width reset
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      hold_cnt_r <= rsl_pkg::RSL_MRST_HOLD_CNT;
    end else if (src_active) begin
      hold_cnt_r <= rsl_pkg::RSL_MRST_HOLD_CNT;
    end else if (hold_cnt_r != 4'h0) begin
      hold_cnt_r <= hold_cnt_r - 4'h1;
    end
  end

  // power-on holds the output high as well
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_master_reset_signal <= 1'b1;
    end else begin
      o_master_reset_signal <= src_active | (hold_cnt_r != 4'h0);
    end
  end

  // ----------------------------------------------------------------
  // wishbone slave decode
  // ----------------------------------------------------------------
  logic req;
  logic wr_cause;
  logic wr_mask;
  logic rd_evstat;

  // one access per request; o_wb_ack blocks a second take of the same one
  assign req       = i_wb_cyc & i_wb_stb & ~o_wb_ack;
  assign wr_cause  = req & i_wb_we & (i_wb_adr == rsl_pkg::RSL_ADR_CAUSE);
  assign wr_mask   = req & i_wb_we & (i_wb_adr == rsl_pkg::RSL_ADR_EVMASK);
  assign rd_evstat = req & ~i_wb_we & (i_wb_adr == rsl_pkg::RSL_ADR_EVSTAT);

  logic [15:0] wmask;

  // byte lanes 0 and 1 hold the 16-bit registers
  assign wmask = {{8{i_wb_sel[1]}}, {8{i_wb_sel[0]}}};

  // ----------------------------------------------------------------
  // reset_cause_status
  // ----------------------------------------------------------------
  logic [15:0] cause_r;
  logic [15:0] cause_nxt;

  // software write first, then hardware set, so a set never gets lost
  always_comb begin
    cause_nxt = cause_r;
    if (wr_cause) begin
      cause_nxt = (cause_r & ~wmask) | (i_wb_dat[15:0] & wmask);
    end
    cause_nxt = (cause_nxt | cause_set) & rsl_pkg::RSL_CAUSE_IMPL;
  end

  // of the resets only power-on clears it; master reset from other sources keeps it
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      cause_r <= rsl_pkg::RSL_CAUSE_RST;
    end else begin
      cause_r <= cause_nxt;
    end
  end

  // flag writes never feed src_active, so writing one starts no reset
  // fuse left unprogrammed overrides the soft enable
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_watchdog_enable <= 1'b1;  // safe side until the fuse is seen
    end else begin
      o_watchdog_enable <= i_watchdog_fuse_enable |
                           cause_r[rsl_pkg::RSL_BIT_WDSEN];
    end
  end

  // ----------------------------------------------------------------
  // interrupt status and mask
  // ----------------------------------------------------------------
  logic [15:0] evstat_r;
  logic [15:0] evstat_nxt;
  logic [15:0] evmask_r;

  // clear on read; an event in the read cycle survives it
  always_comb begin
    evstat_nxt = evstat_r;
    if (rd_evstat) begin
      evstat_nxt = 16'h0000;
    end
    evstat_nxt = (evstat_nxt | ev_set) & rsl_pkg::RSL_CAUSE_IMPL;
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      evstat_r <= rsl_pkg::RSL_EVSTAT_RST;
    end else begin
      evstat_r <= evstat_nxt;
    end
  end

  // mask written through byte lanes
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      evmask_r <= rsl_pkg::RSL_EVMASK_RST;
    end else if (wr_mask) begin
      evmask_r <= ((evmask_r & ~wmask) | (i_wb_dat[15:0] & wmask)) &
                  rsl_pkg::RSL_CAUSE_IMPL;
    end
  end

  // level output, registered from evstat_nxt so it changes in the same cycle as evstat_r
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |(evstat_nxt & evmask_r);
    end
  end

  // ----------------------------------------------------------------
  // wishbone answer
  // ----------------------------------------------------------------
  // ack one cycle after the request, dropped the cycle after
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_wb_ack <= 1'b0;
    end else begin
      o_wb_ack <= req;
    end
  end

  // read data captured with the ack; unmapped addresses read zero
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_wb_dat <= 32'h0000_0000;
    end else if (req & ~i_wb_we) begin
      case (i_wb_adr)
        rsl_pkg::RSL_ADR_CAUSE:  o_wb_dat <= {16'h0000, cause_r};
        rsl_pkg::RSL_ADR_EVSTAT: o_wb_dat <= {16'h0000, evstat_r};
        rsl_pkg::RSL_ADR_EVMASK: o_wb_dat <= {16'h0000, evmask_r};
        default:                 o_wb_dat <= 32'h0000_0000;
      endcase
    end
  end

endmodule

// [rsl_reset_source_status_props.sv]
module rsl_props (
  input wire logic        i_clk,
  input wire logic        i_rst_n,
  input wire logic        i_watchdog_timeout,
  input wire logic        i_trap_conflict,
  input wire logic        i_illegal_opcode,
  input wire logic        i_illegal_addr_mode,
  input wire logic        i_uninit_wreg_ptr,
  input wire logic        i_software_reset,
  input wire logic        i_watchdog_fuse_enable,
  input wire logic        i_wb_cyc,
  input wire logic        i_wb_stb,
  input wire logic [31:0] o_wb_dat,
  input wire logic        o_wb_ack,
  input wire logic        o_master_reset_signal,
  input wire logic        o_watchdog_enable
);
  // ------------------------------------------------------------
  // bus handshake and reset source checks
  // ------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  // a fresh request, and the one-cycle answer it earns
  sequence s_req;      i_wb_cyc && i_wb_stb && !o_wb_ack; endsequence
  sequence s_ack_once; o_wb_ack ##1 !o_wb_ack;            endsequence

  property p_ack_answer; s_req |=> s_ack_once; endproperty
  property p_ack_cause;  o_wb_ack |-> $past(i_wb_cyc && i_wb_stb); endproperty
  property p_dat_upper;  o_wb_ack |-> o_wb_dat[31:16] == 16'h0000; endproperty
  property p_trap_rst;   i_trap_conflict |=> o_master_reset_signal; endproperty
  property p_illop_rst;
    (i_illegal_opcode || i_illegal_addr_mode || i_uninit_wreg_ptr) |=> o_master_reset_signal;
  endproperty
  property p_watchdog_timeout_flag_rst;   i_watchdog_timeout |=> o_master_reset_signal; endproperty
  property p_swr_rst;    i_software_reset |=> o_master_reset_signal; endproperty
  // stretch keeps the core in reset long enough to settle
  property p_stretch;    $fell(i_trap_conflict) |-> o_master_reset_signal [*5]; endproperty
  property p_fuse_wden;  i_watchdog_fuse_enable |=> o_watchdog_enable; endproperty
  // power-on is a source too: master reset still high on release
  property p_por_rst;    $rose(i_rst_n) |-> o_master_reset_signal; endproperty

  a_ack_answer: assert property (p_ack_answer) else $error("no single ack");
  a_ack_cause:  assert property (p_ack_cause) else $error("ack without request");
  a_dat_upper:  assert property (p_dat_upper) else $error("upper read bits set");
  a_trap_rst:   assert property (p_trap_rst) else $error("trap no reset");
  a_illop_rst:  assert property (p_illop_rst) else $error("illegal no reset");
  a_watchdog_timeout_flag_rst:   assert property (p_watchdog_timeout_flag_rst) else $error("wdt no reset");
  a_swr_rst:    assert property (p_swr_rst) else $error("swr no reset");
  a_stretch:    assert property (p_stretch) else $error("reset too short");
  a_fuse_wden:  assert property (p_fuse_wden) else $error("wdt not forced");
  a_por_rst:    assert property (p_por_rst) else $error("no reset after power-on");
endmodule

bind rsl_reset_source_status rsl_props u_props (
  .i_clk(i_clk), .i_rst_n(i_rst_n), .i_watchdog_timeout(i_watchdog_timeout),
  .i_trap_conflict(i_trap_conflict), .i_illegal_opcode(i_illegal_opcode),
  .i_illegal_addr_mode(i_illegal_addr_mode), .i_uninit_wreg_ptr(i_uninit_wreg_ptr),
  .i_software_reset(i_software_reset), .i_watchdog_fuse_enable(i_watchdog_fuse_enable),
  .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack),
  .o_master_reset_signal(o_master_reset_signal), .o_watchdog_enable(o_watchdog_enable));

// [rsl_reset_source_status_tb_top.sv]
module rsl_reset_source_status_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        i_clk = 1'b0;
  logic        i_rst_n = 1'b0;
  logic [7:0]  src = 8'h00;  // trap,illop,addr,uninit,wdt,swr,pin,bor
  logic        fuse = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wdat = 32'h00000000;
  logic [3:0]  sel = 4'h0;
  logic [3:0]  lanes = 4'h3;  // byte lanes used by the next wb call
  logic [31:0] o_wb_dat;
  logic [31:0] rd;
  logic        o_wb_ack, mrst, wden, irq;
  int          failures = 0;
  int          check_count = 0;
  logic [15:0] flag_tab [8] = '{16'h8000, 16'h4000, 16'h4000, 16'h4000,
                               16'h0010, 16'h0040, 16'h0080, 16'h0002};

  always #10 i_clk = ~i_clk;

  rsl_reset_source_status u_dut (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_master_clear_pin_n(~src[6]),
    .i_brownout(src[7]), .i_watchdog_timeout(src[4]), .i_trap_conflict(src[0]),
    .i_illegal_opcode(src[1]), .i_illegal_addr_mode(src[2]), .i_uninit_wreg_ptr(src[3]),
    .i_software_reset(src[5]), .i_watchdog_fuse_enable(fuse), .i_wb_cyc(cyc),
    .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_dat(wdat), .i_wb_sel(sel),
    .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .o_master_reset_signal(mrst),
    .o_watchdog_enable(wden), .o_irq(irq));

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one classic cycle; ack is judged on its pre-edge value
  task automatic wb(input logic w, input logic [7:0] a, input logic [15:0] d);
    int n;
    n = 0;
    @(posedge i_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {16'h0000, d};
    sel <= lanes;
    do begin
      @(posedge i_clk);
      n++;
    end while (o_wb_ack !== 1'b1 && n < 50);
    if (n >= 50) failures++;
    rd = o_wb_dat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [15:0] e, input string what);
    wb(1'b0, a, 16'h0000);
    check(what, {16'h0000, e}, rd);
  endtask

  // hold a source long enough to clear the pin synchroniser
  task automatic pulse(input int k, input int len);
    int n;
    @(posedge i_clk);
    src[k] <= 1'b1;
    repeat (len) @(posedge i_clk);
    check("master reset", 1, mrst);
    src[k] <= 1'b0;
    n = 0;
    while (mrst !== 1'b0 && n < 40) begin
      @(posedge i_clk);
      n++;
    end
    check("master reset released", 0, mrst);
  endtask

  task automatic stop_test();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial begin
    #500_000;
    failures++;
    stop_test();
  end

  initial begin
    repeat (16) @(posedge i_clk);
    i_rst_n <= 1'b1;
    rdchk(8'h00, 16'h0001, "cause after power-on");
    rdchk(8'h04, 16'h0000, "event status");
    rdchk(8'h0C, 16'h0000, "unmapped");
    $display("test power_on done");
    fuse <= 1'b0;
    wb(1'b1, 8'h00, 16'hFFFF);
    rdchk(8'h00, 16'hC0F3, "cause all set");
    repeat (3) @(posedge i_clk);
    check("no reset from write", 0, mrst);
    check("soft wdt enable", 1, wden);
    wb(1'b1, 8'h00, 16'h0000);
    repeat (3) @(posedge i_clk);
    check("soft wdt disable", 0, wden);
    fuse <= 1'b1;
    repeat (3) @(posedge i_clk);
    check("fuse forces wdt", 1, wden);
    $display("test software_flags done");
    for (int k = 0; k < 8; k++) begin
      pulse(k, 6);
      rdchk(8'h00, flag_tab[k], "cause flag");
      check("masked irq", 0, irq);
      wb(1'b1, 8'h00, 16'h0000);
    end
    rdchk(8'h04, 16'hC0D2, "event status all");
    $display("test sources done");
    wb(1'b1, 8'h08, 16'h4000);
    pulse(0, 2);
    check("irq masked", 0, irq);
    rdchk(8'h08, 16'h4000, "mask kept over reset");
    rdchk(8'h04, 16'h8000, "trap event");
    pulse(1, 2);
    check("irq raised", 1, irq);
    rdchk(8'h04, 16'h4000, "illegal event");
    @(posedge i_clk);
    check("irq cleared", 0, irq);
    // upper lane only: low byte must keep its old value
    lanes = 4'h2;
    wb(1'b1, 8'h08, 16'h00FF);
    lanes = 4'h3;
    rdchk(8'h08, 16'h0000, "mask upper lane only");
    $display("test interrupt done");
    wb(1'b1, 8'h00, 16'h00C2);
    @(posedge i_clk);
    i_rst_n <= 1'b0;
    repeat (2) @(posedge i_clk);
    i_rst_n <= 1'b1;
    rdchk(8'h00, 16'h0001, "cause after second power-on");
    rdchk(8'h08, 16'h0000, "mask after power-on");
    $display("test second_reset done");
    stop_test();
  end
endmodule

// [rsl_sync_if.sv]
interface rsl_sync_if;
  logic [rsl_pkg::RSL_NUM_PINS-1:0] raw;    // asynchronous pin levels, active high
  logic [rsl_pkg::RSL_NUM_PINS-1:0] level;  // filtered levels in i_clk domain

  modport sync (input raw, output level);
  modport user (output raw, input level);
endinterface
